// [pkg/spep_pkg.sv]
// Purpose: Shared constants and types of the serial EEPROM protection core
// Assumes: Reference clock of 50 MHz, serial link in clock modes 0 and 3
// Notes: Opcodes, status layout, protection levels and write timing live here
package spep_pkg;
    // Instruction opcodes
    localparam logic [7:0] ARRAY_READ_CMD = 8'h03;
    localparam logic [7:0] ARRAY_WRITE_CMD = 8'h02;
    localparam logic [7:0] STATUS_READ_CMD = 8'h05;
    localparam logic [7:0] STATUS_WRITE_CMD = 8'h01;
    localparam logic [7:0] SET_WRITE_LATCH_CMD = 8'h06;
    localparam logic [7:0] CLEAR_WRITE_LATCH_CMD = 8'h04;

    // Serial framing
    localparam int ADDR_SH_W = 16;
    localparam int BITCNT_W = 4;
    localparam logic [2:0] BYTE_LAST = 3'h7;
    localparam logic [3:0] ADDR_LAST = 4'hF;
    localparam logic [3:0] BITCNT_ONE = 4'h1;
    localparam logic [3:0] BITCNT_ZERO = 4'h0;

    // Page buffer
    localparam int PAGE_BYTES = 32;
    localparam int PAGE_W = 5;

    // Status byte layout
    localparam int BUSY_BIT = 0;
    localparam int WRITE_LATCH_BIT = 1;
    localparam int BLOCK_PROTECT_LOW_BIT = 2;
    localparam int BLOCK_PROTECT_HIGH_BIT = 3;
    localparam int FIXED_ONE_BIT = 5;
    localparam int PIN_PROTECT_BIT = 7;
    localparam logic [2:0] FIXED_MID_BITS = 3'h2;

    // Block protection levels and reset values
    localparam logic [1:0] BP_NONE = 2'h0;
    localparam logic [1:0] BP_QUARTER = 2'h1;
    localparam logic [1:0] BP_HALF = 2'h2;
    localparam logic [1:0] BP_RESET = 2'h0;
    localparam logic PPE_RESET = 1'b0;
    localparam logic [1:0] PIN_IDLE = 2'h3;

    // Internal write cycle duration
    localparam int WRITE_TIME_MS = 5;
    localparam int REF_CLK_HZ = 50_000_000;
    localparam int WRITE_CYCLES_DFLT = WRITE_TIME_MS * (REF_CLK_HZ / 1000);

    typedef enum logic [2:0] {
        ST_OPCODE, ST_ADDR, ST_WR_DATA, ST_RD_ARRAY, ST_RD_STATUS, ST_WR_STATUS, ST_IGNORE
    } spep_state_t;

    typedef enum logic [2:0] {
        FR_NONE, FR_SET_WEL, FR_CLR_WEL, FR_STATUS_WR, FR_ARRAY_WR
    } spep_frame_t;
endpackage

// [logic/spep_core.sv]
// Purpose: Serial slave logic of a small byte-wide EEPROM with block and pin protection
// Assumes: sck is the link clock; cs_n high ends every frame; rst is synchronous
// Notes: Array and page buffer are held here; write cycle length is a parameter
// Operation
// RQ1 - Opcode, address and write data bits are sampled on rising serial clock
// RQ2 - Read data changes on falling serial clock edge
// RQ3 - First byte is instruction; 03h reads array, 05h reads status
// RQ4 - 02h writes array data, 01h writes status from following byte
// RQ5 - Select high floats output and enters standby unless writing
// RQ6 - Each command starts only after select falls
// RQ7 - Programming starts when select rises after complete valid write sequence
// RQ8 - Sixteen address clocks follow; only low 10 or 11 bits decoded
// RQ9 - Status bit 0 is read-only busy flag
// RQ10 - Status bit 1 mirrors write latch; set and clear commands only
// RQ11 - Protect bits select none, top quarter, top half or whole array
// RQ12 - Protect bits loaded by status write; protected addresses are read only
// RQ13 - Enable bit set and protect pin low rejects status writes
// RQ14 - Enable bit clear makes protect pin ignored
// RQ15 - Protect pin falling during status write frame aborts it
// RQ16 - Write latch clear refuses all array and status writes
// RQ17 - Write latch is clear after reset
// RQ18 - Hold low pauses: output floats, input ignored
// RQ19 - Sequential read increments address, wraps to zero, ends at select high
// RQ20 - Status read honoured at any time, even while busy
// RQ21 - Write latch takes effect only after select rises
// RQ22 - Writes to protected addresses are discarded
// RQ23 - While busy all instructions except status read are ignored
// RQ24 - Page write wraps within 32-byte page
// RQ25 - Write latch clears when write cycle completes
// RQ26 - Status write changes only bits 2, 3 and 7
// RQ27 - All bytes travel most significant bit first
`timescale 1ns/100ps
module spep_core import spep_pkg::*; #(
    parameter int ADDR_W = 11,
    parameter int WRITE_CYCLES = WRITE_CYCLES_DFLT
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic sck,
    input wire logic cs_n,
    input wire logic si,
    input wire logic hold_n,
    input wire logic wp_n,
    output logic so_out,
    output logic so_oe,
    output logic standby
);
    localparam int CNT_W = $clog2(WRITE_CYCLES + 1);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(WRITE_CYCLES - 1);
    localparam logic [CNT_W-1:0] CNT_PAGE = CNT_W'(PAGE_BYTES);

    generate
        if (!(ADDR_W == 10 || ADDR_W == 11) || WRITE_CYCLES < PAGE_BYTES + 1) begin : g_bad
            $error("spep_core: unsupported ADDR_W or WRITE_CYCLES");
        end
    endgenerate

    // Array written only in ref_clk domain, read only from the link side
    logic [7:0] mem [2**ADDR_W];
    logic [7:0] page_buf [PAGE_BYTES];

    // Link side state
    spep_state_t state_reg, state_next;
    spep_frame_t frame_kind_reg;
    logic [BITCNT_W-1:0] bit_cnt_reg, bit_cnt_next;
    logic [7:0] shift_reg, shift_next, opcode_reg, wsr_data_reg;
    logic [ADDR_SH_W-1:0] addr_reg;
    logic [PAGE_BYTES-1:0] page_mask_reg;
    logic frame_ok_reg, so_reg, drive_reg;
    logic [7:0] status_s1_reg, status_s2_reg, out_byte;
    logic byte_done, addr_done, busy_s;
    logic [ADDR_W-1:0] ptr;
    logic [PAGE_W-1:0] page_idx;

    // Reference side state
    logic [1:0] pin_s1_reg, pin_s2_reg, pin_s3_reg, pin_f_reg;
    logic cs_f_d_reg, wp_low_seen_reg, wel_reg, busy_reg, prog_array_reg, ppe_reg;
    logic [1:0] bp_reg;
    logic [CNT_W-1:0] busy_cnt_reg;
    logic [7:0] status_view;
    logic cs_f, wp_f, cs_rise, cs_fall, busy_end, accept, status_block;
    logic start_status, start_array;
    logic [PAGE_W-1:0] prog_idx;
    logic [ADDR_W-1:0] prog_addr;

    function automatic logic prot_hit(input logic [ADDR_W-1:0] a, input logic [1:0] bp);
        case (bp)
            BP_NONE: prot_hit = 1'b0;
            BP_QUARTER: prot_hit = a[ADDR_W-1] & a[ADDR_W-2];
            BP_HALF: prot_hit = a[ADDR_W-1];
            default: prot_hit = 1'b1;
        endcase
    endfunction

    // ---------------- Link clock domain ----------------
    assign shift_next = {shift_reg[6:0], si}; // see RQ27
    assign byte_done = (bit_cnt_reg[2:0] == BYTE_LAST);
    assign addr_done = (bit_cnt_reg == ADDR_LAST);
    assign busy_s = status_s2_reg[BUSY_BIT];
    assign ptr = addr_reg[ADDR_W-1:0]; // see RQ8
    assign page_idx = addr_reg[PAGE_W-1:0];

    always_comb begin
        state_next = state_reg;
        bit_cnt_next = (state_reg == ST_ADDR || !byte_done) ? bit_cnt_reg + BITCNT_ONE : BITCNT_ZERO;
        case (state_reg)
            ST_OPCODE: begin
                if (byte_done) begin
                    if (busy_s && shift_next != STATUS_READ_CMD) begin
                        state_next = ST_IGNORE; // see RQ23
                    end else begin
                        case (shift_next) // see RQ3 RQ4
                            ARRAY_READ_CMD: state_next = ST_ADDR;
                            ARRAY_WRITE_CMD: state_next = ST_ADDR;
                            STATUS_READ_CMD: state_next = ST_RD_STATUS; // see RQ20
                            STATUS_WRITE_CMD: state_next = ST_WR_STATUS;
                            default: state_next = ST_IGNORE;
                        endcase
                    end
                end
            end
            ST_ADDR: begin
                if (addr_done) begin
                    state_next = (opcode_reg == ARRAY_READ_CMD) ? ST_RD_ARRAY : ST_WR_DATA;
                end
            end
            default: state_next = state_reg;
        endcase
    end

    // Select high restarts the decoder; sck may stand still outside frames
    always_ff @(posedge sck or posedge cs_n) begin
        if (cs_n) begin
            state_reg <= ST_OPCODE; // see RQ6
            bit_cnt_reg <= BITCNT_ZERO;
        end else if (hold_n) begin
            state_reg <= state_next; // see RQ1 RQ18
            bit_cnt_reg <= bit_cnt_next;
        end
    end

    // Frame results are kept past select rise for the reference side to take
    always_ff @(posedge sck) begin
        if (!cs_n && hold_n) begin
            shift_reg <= shift_next; // see RQ1
            case (state_reg)
                ST_OPCODE: begin
                    if (bit_cnt_reg == BITCNT_ZERO) begin
                        frame_kind_reg <= FR_NONE;
                        frame_ok_reg <= 1'b0;
                    end else if (byte_done && (!busy_s || shift_next == STATUS_READ_CMD)) begin
                        opcode_reg <= shift_next;
                        case (shift_next)
                            SET_WRITE_LATCH_CMD: begin
                                frame_kind_reg <= FR_SET_WEL;
                                frame_ok_reg <= 1'b1;
                            end
                            CLEAR_WRITE_LATCH_CMD: begin
                                frame_kind_reg <= FR_CLR_WEL;
                                frame_ok_reg <= 1'b1;
                            end
                            STATUS_WRITE_CMD: frame_kind_reg <= FR_STATUS_WR;
                            // Mask cleared only by a taken write, so polling keeps the page
                            ARRAY_WRITE_CMD: begin
                                frame_kind_reg <= FR_ARRAY_WR;
                                page_mask_reg <= '0;
                            end
                            default: frame_kind_reg <= FR_NONE;
                        endcase
                    end
                end
                ST_ADDR: addr_reg <= {addr_reg[ADDR_SH_W-2:0], si}; // see RQ8
                ST_RD_ARRAY: begin
                    if (byte_done) begin
                        addr_reg[ADDR_W-1:0] <= ptr + 1'b1; // see RQ19
                    end
                end
                ST_WR_DATA: begin
                    if (byte_done) begin
                        page_buf[page_idx] <= shift_next;
                        page_mask_reg[page_idx] <= 1'b1;
                        addr_reg[PAGE_W-1:0] <= page_idx + 1'b1; // see RQ24
                        frame_ok_reg <= 1'b1;
                    end else if (bit_cnt_reg == BITCNT_ZERO) begin
                        frame_ok_reg <= 1'b0; // see RQ7
                    end
                end
                ST_WR_STATUS: begin
                    if (byte_done) begin
                        wsr_data_reg <= shift_next;
                        frame_ok_reg <= 1'b1;
                    end else if (bit_cnt_reg == BITCNT_ZERO) begin
                        frame_ok_reg <= 1'b0;
                    end
                end
                default: ;
            endcase
        end
    end

    // Status bits are independent levels, each crossed by two flops
    always_ff @(posedge sck) begin
        status_s1_reg <= status_view;
        status_s2_reg <= status_s1_reg;
    end

    // Array is stable here: reads are refused while a write cycle runs
    assign out_byte = (state_reg == ST_RD_STATUS) ? status_s2_reg : mem[ptr];

    always_ff @(negedge sck or posedge cs_n) begin
        if (cs_n) begin
            so_reg <= 1'b0;
            drive_reg <= 1'b0;
        end else if (hold_n) begin
            so_reg <= out_byte[BYTE_LAST - bit_cnt_reg[2:0]]; // see RQ2 RQ27
            drive_reg <= (state_reg == ST_RD_ARRAY) || (state_reg == ST_RD_STATUS);
        end
    end

    assign so_out = so_reg;
    assign so_oe = drive_reg & hold_n & ~cs_n; // see RQ5 RQ18

    // ---------------- Reference clock domain ----------------
    // Three stages; a pin change counts once stages two and three agree
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pin_s1_reg <= PIN_IDLE;
            pin_s2_reg <= PIN_IDLE;
            pin_s3_reg <= PIN_IDLE;
            pin_f_reg <= PIN_IDLE;
            cs_f_d_reg <= 1'b1;
        end else begin
            pin_s1_reg <= {wp_n, cs_n};
            pin_s2_reg <= pin_s1_reg;
            pin_s3_reg <= pin_s2_reg;
            pin_f_reg <= (pin_s2_reg & ~(pin_s2_reg ^ pin_s3_reg))
                | (pin_f_reg & (pin_s2_reg ^ pin_s3_reg));
            cs_f_d_reg <= pin_f_reg[0];
        end
    end

    assign cs_f = pin_f_reg[0];
    assign wp_f = pin_f_reg[1];
    assign cs_rise = cs_f & ~cs_f_d_reg;
    assign cs_fall = ~cs_f & cs_f_d_reg;
    assign busy_end = busy_reg && (busy_cnt_reg == CNT_LAST);
    assign accept = cs_rise && !busy_reg && frame_ok_reg; // see RQ7 RQ23
    assign status_block = ppe_reg & wp_low_seen_reg; // see RQ13 RQ14 RQ15
    assign start_status = accept && frame_kind_reg == FR_STATUS_WR && wel_reg && !status_block;
    assign start_array = accept && frame_kind_reg == FR_ARRAY_WR && wel_reg; // see RQ16

    // With the enable bit set, any low protect pin level seen during the frame spoils a status write
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wp_low_seen_reg <= 1'b0;
        end else begin
            wp_low_seen_reg <= (!cs_f && !wp_f) | (wp_low_seen_reg & ~cs_fall); // see RQ15
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wel_reg <= 1'b0; // see RQ17
        end else if (busy_end) begin
            wel_reg <= 1'b0; // see RQ25
        end else if (accept && frame_kind_reg == FR_SET_WEL) begin
            wel_reg <= 1'b1; // see RQ10 RQ21
        end else if (accept && frame_kind_reg == FR_CLR_WEL) begin
            wel_reg <= 1'b0; // see RQ10
        end
    end

    // Protect bits reset to no protection; retention across power is not modelled
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            bp_reg <= BP_RESET;
            ppe_reg <= PPE_RESET;
        end else if (start_status) begin
            bp_reg <= wsr_data_reg[BLOCK_PROTECT_HIGH_BIT:BLOCK_PROTECT_LOW_BIT]; // see RQ12 RQ26
            ppe_reg <= wsr_data_reg[PIN_PROTECT_BIT];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            busy_reg <= 1'b0;
            prog_array_reg <= 1'b0;
            busy_cnt_reg <= '0;
        end else if (start_status || start_array) begin
            busy_reg <= 1'b1; // see RQ7 RQ9
            prog_array_reg <= start_array;
            busy_cnt_reg <= '0;
        end else if (busy_reg) begin
            busy_reg <= !busy_end;
            busy_cnt_reg <= busy_cnt_reg + 1'b1;
        end
    end

    // One page byte per cycle at the start of the write cycle
    assign prog_idx = busy_cnt_reg[PAGE_W-1:0];
    assign prog_addr = {addr_reg[ADDR_W-1:PAGE_W], prog_idx};

    always_ff @(posedge ref_clk) begin
        if (busy_reg && prog_array_reg && busy_cnt_reg < CNT_PAGE && page_mask_reg[prog_idx]
            && !prot_hit(prog_addr, bp_reg)) begin
            mem[prog_addr] <= page_buf[prog_idx]; // see RQ11 RQ12 RQ22
        end
    end

    always_comb begin
        status_view = '0;
        status_view[BUSY_BIT] = busy_reg; // see RQ9
        status_view[WRITE_LATCH_BIT] = wel_reg; // see RQ10
        status_view[BLOCK_PROTECT_HIGH_BIT:BLOCK_PROTECT_LOW_BIT] = bp_reg;
        status_view[FIXED_ONE_BIT] = 1'b1;
        status_view[PIN_PROTECT_BIT] = ppe_reg;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            standby <= 1'b1;
        end else begin
            standby <= cs_f & ~busy_reg; // see RQ5
        end
    end

    // ---------------- Assertions ----------------
    a_set_write_latch_cmd_sets_latch: assert property (@(posedge ref_clk) disable iff (rst) // see RQ21
        (accept && frame_kind_reg == FR_SET_WEL) |=> wel_reg)
        else $error("write latch not set after set-latch frame");
    a_clear_write_latch_cmd_clears: assert property (@(posedge ref_clk) disable iff (rst) // see RQ10
        (accept && frame_kind_reg == FR_CLR_WEL) |=> !wel_reg)
        else $error("write latch not cleared after clear-latch frame");
    a_no_wel_no_write: assert property (@(posedge ref_clk) disable iff (rst) // see RQ16
        (cs_rise && !wel_reg && !busy_reg) |=> !busy_reg)
        else $error("write cycle started with write latch clear");
    a_busy_holds: assert property (@(posedge ref_clk) disable iff (rst) // see RQ9
        $rose(busy_reg) |-> busy_reg [*8])
        else $error("busy flag dropped early");
    a_latch_auto_clear: assert property (@(posedge ref_clk) disable iff (rst) // see RQ25
        $fell(busy_reg) |-> !wel_reg)
        else $error("write latch still set after write cycle");
    a_pin_blocks_status: assert property (@(posedge ref_clk) disable iff (rst) // see RQ13
        (cs_rise && ppe_reg && wp_low_seen_reg) |=> $stable(bp_reg) && $stable(ppe_reg))
        else $error("status written while pin protected");
    a_fixed_status_bits: assert property (@(posedge ref_clk) disable iff (rst) // see RQ26
        status_view[6:4] == FIXED_MID_BITS)
        else $error("fixed status bits changed");
    a_latch_after_reset: assert property (@(posedge ref_clk) disable iff (rst) // see RQ17
        $past(rst) |-> !wel_reg && !busy_reg)
        else $error("write latch set after reset");
    a_read_wraps: assert property (@(posedge sck) disable iff (cs_n) // see RQ19
        (hold_n && state_reg == ST_RD_ARRAY && byte_done && &ptr) |=> ptr == '0)
        else $error("read address did not wrap to zero");
    a_busy_ignores: assert property (@(posedge sck) disable iff (cs_n) // see RQ23
        (hold_n && state_reg == ST_OPCODE && byte_done && busy_s
            && shift_next != STATUS_READ_CMD) |=> state_reg == ST_IGNORE)
        else $error("instruction accepted while busy");
    a_float_when_idle: assert property (@(posedge ref_clk) disable iff (rst) // see RQ5
        (cs_f && pin_s1_reg[0]) |-> !so_oe)
        else $error("output driven while deselected");

    c_set_write_latch_cmd_frame: cover property (@(posedge ref_clk) disable iff (rst)
        accept && frame_kind_reg == FR_SET_WEL);
    c_array_write: cover property (@(posedge ref_clk) disable iff (rst) start_array);
    c_status_write: cover property (@(posedge ref_clk) disable iff (rst) start_status);
    c_read_wrap: cover property (@(posedge sck) disable iff (cs_n)
        state_reg == ST_RD_ARRAY && byte_done && &ptr);
    // Refused opcode while programming, the case polling hosts hit
    c_busy_ignored: cover property (@(posedge sck) disable iff (cs_n)
        state_reg == ST_OPCODE && byte_done && busy_s
            && shift_next != STATUS_READ_CMD);
endmodule

// [testbench/spep_host_model.sv]
// Purpose: SPI host at the far side of the core, modes 0 and 3
// Assumes: Link clock half period 3 ns, standing still outside frames
// Notes: A floating output reads as the inverse of its last level
`timescale 1ns/100ps
module spep_host_model (
    input wire logic so_out,
    input wire logic so_oe,
    output logic sck,
    output logic cs_n,
    output logic si,
    output logic hold_n
);
    logic mode3 = 1'b0;
    logic last = 1'b0;
    logic so_ln;
    // No pull-up on the output, so a stale level must not pass for data
    assign so_ln = so_oe ? so_out : ~last;
    always @(so_out or so_oe) begin
        if (so_oe) last = so_out;
    end
    initial begin
        sck = 1'b0;
        cs_n = 1'b1;
        si = 1'b0;
        hold_n = 1'b1;
    end
    task automatic set_mode(input logic m);
        mode3 = m;
        sck <= m;
        #3;
    endtask
    task automatic open_frame();
        cs_n <= 1'b0;
        #5;
    endtask
    task automatic close_frame();
        sck <= mode3;
        #3;
        cs_n <= 1'b1;
        #200;
    endtask
    task automatic xfer(input logic [7:0] d, output logic [7:0] q);
        for (int i = 7; i >= 0; i--) begin
            sck <= 1'b0;
            si <= d[i];
            #3;
            q[i] = so_ln;
            sck <= 1'b1;
            #3;
        end
    endtask
    task automatic set_hold(input logic v);
        sck <= 1'b0;
        si <= ~si;
        #3;
        hold_n <= v;
        #3;
    endtask
endmodule

// [testbench/spep_core_tb_top.sv]
// Purpose: Self-checking bench of the serial EEPROM protection core
// Assumes: Write cycle shortened to 40 clocks, 11 address bits
// Notes: Array is not reset, so only locations written here are compared
`timescale 1ns/100ps
module spep_core_tb_top import spep_pkg::*;;
    int mismatches = 0;
    int comparisons = 0;
    logic ref_clk, rst, wp_n, sck, cs_n, si, hold_n, so_out, so_oe, standby;
    logic [7:0] s;
    logic [7:0] wb [6];
    logic [7:0] eb [6];
    logic [15:0] ok_a [4] = '{16'h0000, 16'h05FF, 16'h03FF, 16'h0000};
    logic [15:0] pr_a [4] = '{16'h0000, 16'h07FF, 16'h07E0, 16'h0000};
    logic [7:0] pr_d [4] = '{8'h00, 8'h18, 8'hF0, 8'h5A};
    spep_core #(.WRITE_CYCLES(40)) dut (.ref_clk(ref_clk), .rst(rst),
        .sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n), .wp_n(wp_n),
        .so_out(so_out), .so_oe(so_oe), .standby(standby));
    spep_host_model host (.so_out(so_out), .so_oe(so_oe), .sck(sck), .cs_n(cs_n),
        .si(si), .hold_n(hold_n));
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmd(input logic [7:0] op);
        logic [7:0] q;
        host.open_frame();
        host.xfer(op, q);
        host.close_frame();
    endtask
    task automatic frame2(input logic [7:0] op, input logic [7:0] v, output logic [7:0] r);
        logic [7:0] q;
        host.open_frame();
        host.xfer(op, q);
        host.xfer(v, r);
        host.close_frame();
    endtask
    task automatic chk(input logic [7:0] e);
        frame2(STATUS_READ_CMD, 8'h00, s);
        check(s, e);
    endtask
    task automatic access(input logic pre, input logic [7:0] op, input logic [15:0] a,
        input int n);
        logic [7:0] q;
        host.open_frame();
        if (pre) host.xfer(SET_WRITE_LATCH_CMD, q);
        host.xfer(op, q);
        host.xfer(a[15:8], q);
        host.xfer(a[7:0], q);
        for (int i = 0; i < n; i++) begin
            host.xfer(wb[i], q);
            if (op == ARRAY_READ_CMD) check(q, eb[i]);
        end
        host.close_frame();
    endtask
    task automatic wait_ready();
        s = 8'h01;
        for (int k = 0; k < 20 && s[0] !== 1'b0; k++) frame2(STATUS_READ_CMD, 8'h00, s);
        check({7'h00, s[0]}, 8'h00);
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        cmd(SET_WRITE_LATCH_CMD);
        wb[0] = d;
        access(1'b0, ARRAY_WRITE_CMD, a, 1);
        wait_ready();
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] d);
        eb[0] = d;
        access(1'b0, ARRAY_READ_CMD, a, 1);
    endtask
    task automatic sts(input logic [7:0] v);
        cmd(SET_WRITE_LATCH_CMD);
        frame2(STATUS_WRITE_CMD, v, s);
        wait_ready();
    endtask
    task automatic end_test(input string n);
        $display("test %s finished", n);
    endtask
    // Whole run needs about 36 us; the limit leaves ample margin
    initial begin
        #400000;
        mismatches++;
        summarize();
    end
    initial begin
        rst = 1'b1;
        wp_n = 1'b1;
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (6) @(posedge ref_clk);
        check({7'h00, standby}, 8'h01);
        check({7'h00, so_oe}, 8'h00);
        chk(8'h20);
        cmd(SET_WRITE_LATCH_CMD);
        chk(8'h22);
        cmd(CLEAR_WRITE_LATCH_CMD);
        chk(8'h20);
        end_test("latch");
        wb = '{8'h5A, 8'hC3, 8'h00, 8'h00, 8'h00, 8'h00};
        cmd(SET_WRITE_LATCH_CMD);
        access(1'b0, ARRAY_WRITE_CMD, 16'h0000, 2);
        check({7'h00, standby}, 8'h00);
        chk(8'h23);
        wait_ready();
        chk(8'h20);
        wb = '{8'h81, 8'h42, 8'h24, 8'h18, 8'hF0, 8'h0F};
        cmd(SET_WRITE_LATCH_CMD);
        access(1'b0, ARRAY_WRITE_CMD, 16'hF7FC, 6);
        wait_ready();
        eb = '{8'h24, 8'h18, 8'h5A, 8'hC3, 8'h00, 8'h00};
        access(1'b0, ARRAY_READ_CMD, 16'hF7FE, 4);
        host.set_mode(1'b1);
        eb = '{8'hF0, 8'h0F, 8'h00, 8'h00, 8'h00, 8'h00};
        access(1'b0, ARRAY_READ_CMD, 16'h07E0, 2);
        host.set_mode(1'b0);
        end_test("array");
        wb[0] = 8'hFF;
        access(1'b1, ARRAY_WRITE_CMD, 16'h0000, 1);
        chk(8'h22);
        rd(16'h0000, 8'h5A);
        cmd(CLEAR_WRITE_LATCH_CMD);
        access(1'b0, ARRAY_WRITE_CMD, 16'h0000, 1);
        chk(8'h20);
        rd(16'h0000, 8'h5A);
        cmd(SET_WRITE_LATCH_CMD);
        wb[0] = 8'h11;
        access(1'b0, ARRAY_WRITE_CMD, 16'h0001, 1);
        // Second write arrives while the first is still programming
        wb[0] = 8'h77;
        access(1'b0, ARRAY_WRITE_CMD, 16'h0000, 1);
        wait_ready();
        rd(16'h0000, 8'h5A);
        rd(16'h0001, 8'h11);
        end_test("refusal");
        for (int bp = 1; bp < 4; bp++) begin
            sts({1'b1, 3'b111, bp[1:0], 2'b11});
            chk({4'hA, bp[1:0], 2'b00});
            if (bp < 3) wr(ok_a[bp], 8'h3C);
            if (bp < 3) rd(ok_a[bp], 8'h3C);
            wr(pr_a[bp], 8'hE7);
            cmd(CLEAR_WRITE_LATCH_CMD);
            rd(pr_a[bp], pr_d[bp]);
        end
        @(posedge ref_clk) wp_n <= 1'b0;
        sts(8'h00);
        cmd(CLEAR_WRITE_LATCH_CMD);
        chk(8'hAC);
        @(posedge ref_clk) wp_n <= 1'b1;
        cmd(SET_WRITE_LATCH_CMD);
        host.open_frame();
        host.xfer(STATUS_WRITE_CMD, s);
        host.xfer(8'h00, s);
        @(posedge ref_clk) wp_n <= 1'b0;
        repeat (5) @(posedge ref_clk);
        wp_n <= 1'b1;
        repeat (5) @(posedge ref_clk);
        host.close_frame();
        wait_ready();
        cmd(CLEAR_WRITE_LATCH_CMD);
        chk(8'hAC);
        sts(8'h00);
        chk(8'h20);
        @(posedge ref_clk) wp_n <= 1'b0;
        sts(8'h0C);
        chk(8'h2C);
        end_test("protect");
        host.open_frame();
        host.xfer(STATUS_READ_CMD, s);
        host.set_hold(1'b0);
        #200;
        check({7'h00, so_oe}, 8'h00);
        check({7'h00, standby}, 8'h00);
        host.set_hold(1'b1);
        host.xfer(8'h00, s);
        check(s, 8'h2C);
        host.close_frame();
        end_test("hold");
        summarize();
    end
endmodule
